// ### bench/fllcs_osc_model.sv
module fllcs_osc_model
    import fllcs_pkg::*;
(
    input wire logic [2:0] dco_tap, // tap chosen by the loop
    output logic [7:0] src_clk_pins, // crystal and bypass sources
    output logic loop_reference_clock, // reference crystal
    output logic dco_clk_pin // oscillator feedback
);
    timeunit 1ns;
    timeprecision 1ps;

    // ************
    // free running sources
    // ************
    // a 2 ns offset keeps every source edge off the pclk rising edge
    for (genvar i = 0; i < 8; i++) begin : g_src
        initial begin
            src_clk_pins[i] = 1'b0;
            #2;
            forever #((i + 2) * 16) src_clk_pins[i] = ~src_clk_pins[i];
        end
    end

    initial begin
        loop_reference_clock = 1'b0;
        #3;
        forever #50 loop_reference_clock = ~loop_reference_clock;
    end

    // a higher tap gives a shorter period, as the real oscillator does
    initial begin
        dco_clk_pin = 1'b0;
        #1;
        forever #(44 - 4 * int'(dco_tap)) dco_clk_pin = ~dco_clk_pin;
    end
endmodule

// ### bench/tb_top.sv
`include "fllcs_map.svh"
module tb_top
    import fllcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [11:0] A_SEL = `FLLCS_OFF_CLKSEL;
    localparam logic [11:0] A_CTL = `FLLCS_OFF_OSCCTL;
    localparam logic [11:0] A_FLT = `FLLCS_OFF_FAULT;
    localparam logic [11:0] A_MSK = `FLLCS_OFF_MASK;
    localparam logic [11:0] A_TGT = `FLLCS_OFF_TARGET;
    localparam logic [11:0] A_WRD = `FLLCS_OFF_DCOWORD;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic osc1_fail_pin = 1'b0;
    logic osc2_fail_pin = 1'b0;
    logic sleep_req = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, main_clk, sub_clk, aux_clk;
    logic osc1_bypass, osc1_hf, osc2_bypass, low_current_mode, osc_fault_nmi, irq;
    logic [7:0] src_clk_pins, h0, h1, h2;
    logic loop_reference_clock, dco_clk_pin;
    logic [2:0] dco_tap;
    int failures = 0;
    int n_checks = 0;

    always #4 pclk = ~pclk;

    always @(posedge pclk) begin
        h0 <= src_clk_pins;
        h1 <= h0;
        h2 <= h1;
    end

    fllcs_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .src_clk_pins(src_clk_pins),
        .loop_reference_clock(loop_reference_clock), .dco_clk_pin(dco_clk_pin),
        .osc1_fail_pin(osc1_fail_pin), .osc2_fail_pin(osc2_fail_pin), .sleep_req(sleep_req),
        .main_clk(main_clk), .sub_clk(sub_clk), .aux_clk(aux_clk), .dco_tap(dco_tap),
        .osc1_bypass(osc1_bypass), .osc1_hf(osc1_hf), .osc2_bypass(osc2_bypass),
        .low_current_mode(low_current_mode), .osc_fault_nmi(osc_fault_nmi), .irq(irq));

    fllcs_osc_model osc (.dco_tap(dco_tap), .src_clk_pins(src_clk_pins),
        .loop_reference_clock(loop_reference_clock), .dco_clk_pin(dco_clk_pin));

    // ************
    // bus and check helpers
    // ************
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one idle edge first, so psel is never assigned twice in a time step
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        xfer(a, 1'b1, d, r, e);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        logic e;
        xfer(a, 1'b0, 32'h0, r, e);
    endtask

    task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        rd(a, r);
        chk(what, r, exp);
    endtask

    // ************
    // scenarios
    // ************
    task automatic t_reset();
        logic [31:0] r;
        logic e;
        rdc("clk_select_reg", A_SEL, 32'h0);
        rdc("osc_control_reg", A_CTL, 32'h0);
        rdc("osc_fault_reg", A_FLT, 32'h0);
        rdc("mask", A_MSK, 32'h0);
        rdc("target", A_TGT, 32'h0000_001F);
        rdc("dco word", A_WRD, 32'h0000_0080);
        xfer(12'h018, 1'b0, 32'h0, r, e);
        chk("unmapped err", 32'(e), 32'h1);
        chk("unmapped data", r, 32'h0);
        $display("reset test done");
    endtask

    task automatic t_select();
        logic [2:0] m, s, a;
        wr(A_CTL, 32'h0);
        for (int i = 0; i < 8; i++) begin
            m = 3'(i);
            s = 3'(i + 3);
            a = 3'(i + 5);
            wr(A_SEL, {21'h0, a, 1'b0, s, 1'b0, m});
            repeat (4) @(posedge pclk);
            repeat (40) begin
                @(posedge pclk);
                #1;
                chk("main_clk", 32'(main_clk), 32'(h2[m]));
                chk("sub_clk", 32'(sub_clk), 32'(h2[s]));
                chk("aux_clk", 32'(aux_clk), 32'(h2[a]));
            end
            rdc("fault after select", A_FLT, 32'h0);
            wr(A_FLT, 32'h0000_0007);
        end
        $display("select test done");
    endtask

    task automatic t_fault();
        wr(A_CTL, 32'h0000_0200);
        wr(A_MSK, 32'h0000_0001);
        osc1_fail_pin <= 1'b1;
        repeat (4) @(posedge pclk);
        #1;
        chk("nmi osc1", 32'(osc_fault_nmi), 32'h1);
        chk("irq osc1", 32'(irq), 32'h1);
        wr(A_FLT, 32'h0000_0001);
        rdc("flag held by pin", A_FLT, 32'h0000_0001);
        osc1_fail_pin <= 1'b0;
        osc2_fail_pin <= 1'b1;
        repeat (4) @(posedge pclk);
        wr(A_FLT, 32'h0000_0001);
        rdc("osc2 only", A_FLT, 32'h0000_0002);
        #1;
        chk("irq masked", 32'(irq), 32'h0);
        chk("nmi osc2", 32'(osc_fault_nmi), 32'h1);
        wr(A_CTL, 32'h0);
        #1;
        chk("nmi disabled", 32'(osc_fault_nmi), 32'h0);
        osc2_fail_pin <= 1'b0;
        repeat (4) @(posedge pclk);
        wr(A_FLT, 32'h0000_0007);
        rdc("flags cleared", A_FLT, 32'h0);
        $display("fault test done");
    endtask

    task automatic t_sleep();
        logic [31:0] v;
        for (int k = 0; k < 2; k++) begin
            v = (k == 0) ? 32'h0000_0007 : 32'h0;
            wr(A_CTL, v);
            #1;
            chk("bypass pins", {29'h0, osc2_bypass, osc1_hf, osc1_bypass}, v);
            @(posedge pclk);
            sleep_req <= 1'b1;
            #1;
            chk("low current early", 32'(low_current_mode), 32'h0);
            @(posedge pclk);
            #1;
            chk("low current", 32'(low_current_mode), 32'h1);
            sleep_req <= 1'b0;
        end
        $display("sleep test done");
    endtask

    task automatic t_mod();
        logic [23:0] wv = 24'h50_40FF;
        logic [23:0] mv = 24'h0C_0480;
        logic [7:0] seen;
        for (int k = 2; k >= 0; k--) begin
            wr(A_WRD, {24'h0, wv[8*k +: 8]});
            // the old word's tap stands until the next oscillator edge reaches the modulator
            repeat (20) @(posedge pclk);
            seen = 8'h00;
            repeat (400) begin
                @(posedge pclk);
                #1;
                seen[dco_tap] = 1'b1;
            end
            chk("taps used", {24'h0, seen}, {24'h0, mv[8*k +: 8]});
        end
        $display("modulation test done");
    endtask

    // step is the expected change of the whole word per reference period
    task automatic t_track(input logic [7:0] start, input logic [9:0] tgt, input logic [7:0] step);
        logic [31:0] r;
        logic [7:0] prev;
        int moves;
        wr(A_CTL, 32'h0);
        wr(A_WRD, {24'h0, start});
        wr(A_TGT, {22'h0, tgt});
        wr(A_CTL, 32'h0000_0100);
        prev = start;
        moves = 0;
        repeat (80) begin
            rd(A_WRD, r);
            if (r[7:0] !== prev) begin
                chk("word step", {24'h0, r[7:0]}, {24'h0, 8'(prev + step)});
                prev = r[7:0];
                moves++;
            end
        end
        chk("loop tracking", 32'(moves > 5), 32'h1);
        wr(A_WRD, 32'h0000_0011);
        rd(A_WRD, r);
        chk("word write while locked", 32'(r[7:0] == 8'h11), 32'h0);
        $display("tracking test done");
    endtask

    task automatic t_settle();
        logic [31:0] r;
        wr(A_CTL, 32'h0);
        wr(A_FLT, 32'h0000_0007);
        wr(A_MSK, 32'h0000_0004);
        wr(A_CTL, 32'h0000_0100);
        repeat (1000) @(posedge loop_reference_clock);
        rd(A_WRD, r);
        chk("settled early", 32'(r[16]), 32'h0);
        chk("irq early", 32'(irq), 32'h0);
        // software waits the full 32 x 32 reference periods before trusting lock
        repeat (28) @(posedge loop_reference_clock);
        repeat (5) @(posedge pclk);
        rd(A_WRD, r);
        chk("settled", 32'(r[16]), 32'h1);
        rdc("settle event", A_FLT, 32'h0000_0004);
        #1;
        chk("settle irq", 32'(irq), 32'h1);
        wr(A_FLT, 32'h0000_0004);
        #1;
        chk("irq cleared", 32'(irq), 32'h0);
        wr(A_CTL, 32'h0);
        rd(A_WRD, r);
        chk("settled after off", 32'(r[16]), 32'h0);
        $display("settle test done");
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // the settle wait dominates: about 13000 cycles of some 15000 in all
    initial begin
        #(8 * 60000);
        failures++;
        $display("watchdog expired");
        complete_run();
    end

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_select();
        t_fault();
        t_sleep();
        t_mod();
        t_track(8'h7F, 10'h3FF, 8'h01);
        t_track(8'h80, 10'h000, 8'hFF);
        t_settle();
        complete_run();
    end
endmodule

// ### rtl/fllcs_map.svh
`ifndef FLLCS_MAP_SVH
`define FLLCS_MAP_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define FLLCS_OFF_CLKSEL 12'h000
`define FLLCS_OFF_OSCCTL 12'h004
`define FLLCS_OFF_FAULT 12'h008
`define FLLCS_OFF_MASK 12'h00C
`define FLLCS_OFF_TARGET 12'h010
`define FLLCS_OFF_DCOWORD 12'h014

// ****************************************************************
// field positions
// ****************************************************************
`define FLLCS_MAIN_LSB 0
`define FLLCS_SUB_LSB 4
`define FLLCS_AUX_LSB 8
`define FLLCS_SEL_W 3
`define FLLCS_TAP_LSB 8
`define FLLCS_SETTLED_BIT 16
`define FLLCS_FLAG_W 3
`define FLLCS_TARGET_W 10

// ****************************************************************
// reset values and timing counts
// ****************************************************************
`define FLLCS_RST_CLKSEL 9'h000
`define FLLCS_RST_OSCCTL 5'h00
`define FLLCS_RST_MASK 3'h0
`define FLLCS_RST_TARGET 10'h01F
`define FLLCS_RST_WORD 8'h80
`define FLLCS_SETTLE_REFS 1024

`endif

// ### rtl/fllcs_modulator.sv
module fllcs_modulator
    import fllcs_pkg::*;
#(
    parameter int TAP_W = 3,
    parameter int MOD_W = 5
) (
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic tick, // one oscillator period elapsed
    input wire logic [TAP_W-1:0] osc_tap_sel, // selected tap
    input wire logic [MOD_W-1:0] mod_fraction, // fraction in 1/32 steps
    output logic [TAP_W-1:0] tap_out // tap driven this period
);

    logic [MOD_W-1:0] acc_r;
    logic [MOD_W-1:0] acc_nxt;
    logic carry;
    logic top_tap;

    // below the top tap, carry out of the accumulator spends mod_fraction periods of 32 on tap+1
    assign {carry, acc_nxt} = {1'b0, acc_r} + {1'b0, mod_fraction};
    assign top_tap = &osc_tap_sel;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_r <= '0;
            tap_out <= '0;
        end else if (tick) begin
            acc_r <= acc_nxt;
            tap_out <= (carry && !top_tap) ? osc_tap_sel + 1'b1 : osc_tap_sel;
        end
    end

    a_plain_tap: assert property (@(posedge pclk) disable iff (!presetn)
        (tick && mod_fraction == '0) |=> tap_out == $past(osc_tap_sel))
        else $error("tap moved with zero fraction");

endmodule

// ### rtl/fllcs_pkg.sv
package fllcs_pkg;

    typedef enum logic [1:0] {
        FLLCS_OFF   = 2'b00,
        FLLCS_ARM   = 2'b01,
        FLLCS_TRACK = 2'b10
    } fllcs_state_t;

    typedef struct packed {
        logic [2:0] aux;
        logic [2:0] sub;
        logic [2:0] main;
    } fllcs_sel_t;

    typedef struct packed {
        logic nmi_en;
        logic fll_en;
        logic osc2_bypass;
        logic osc1_hf_mode;
        logic osc1_bypass_bit;
    } fllcs_octl_t;

    typedef struct packed {
        logic settled;
        logic osc2_fault;
        logic osc1_fault;
    } fllcs_flags_t;

endpackage

// ### rtl/fllcs_top.sv
`include "fllcs_map.svh"

// Overview of operation
// - with the loop enabled the tap and fraction word follow the target automatically.
// - below the top tap the fraction alternates the oscillator between the chosen tap and the next one up.
// - crossing a tap boundary rolls the fraction over and never bumps tap while lowering it.
// - the word moves one step per reference period so no large transient jump occurs.
// - the loop is settled after 32 x 32 reference periods and software waits that long.
// - writing a clock source select reroutes that clock to the new source.
// - changing a clock source select never sets an oscillator fault flag by itself.
// - a set fault flag with the fault nmi enabled raises the nmi.
// - deepest sleep entry switches the power manager to low current whatever the bypass.
module fllcs_top
    import fllcs_pkg::*;
#(
    parameter int NSRC = 8,
    parameter int TAP_W = 3,
    parameter int MOD_W = 5,
    parameter int CNT_W = 10
) (
    input wire logic pclk, // system clock, 125 MHz
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic [NSRC-1:0] src_clk_pins, // candidate clock sources
    input wire logic loop_reference_clock, // loop reference pin
    input wire logic dco_clk_pin, // oscillator output fed back
    input wire logic osc1_fail_pin, // crystal one fault detector
    input wire logic osc2_fail_pin, // crystal two fault detector
    input wire logic sleep_req, // deepest sleep mode request
    output logic main_clk, // main clock level
    output logic sub_clk, // subsystem clock level
    output logic aux_clk, // auxiliary clock level
    output logic [TAP_W-1:0] dco_tap, // tap driven to oscillator
    output logic osc1_bypass, // crystal one bypass drive
    output logic osc1_hf, // crystal one high frequency mode
    output logic osc2_bypass, // crystal two bypass drive
    output logic low_current_mode, // power manager low current
    output logic osc_fault_nmi, // oscillator fault nmi level
    output logic irq // maskable interrupt level
);

    localparam int W = TAP_W + MOD_W;
    localparam int NPIN = NSRC + 4;

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] meta_r;
    logic [NPIN-1:0] sync_r;
    assign pin_raw = {osc2_fail_pin, osc1_fail_pin, dco_clk_pin, loop_reference_clock,
        src_clk_pins};

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta_r[gi] <= 1'b0;
                    sync_r[gi] <= 1'b0;
                end else begin
                    meta_r[gi] <= pin_raw[gi];
                    sync_r[gi] <= meta_r[gi];
                end
            end
        end
    endgenerate

    wire [NSRC-1:0] src_s = sync_r[NSRC-1:0];
    wire ref_s = sync_r[NSRC];
    wire dco_s = sync_r[NSRC+1];
    wire f1_s = sync_r[NSRC+2];
    wire f2_s = sync_r[NSRC+3];

    logic ref_d_r;
    logic dco_d_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_d_r <= 1'b0;
            dco_d_r <= 1'b0;
        end else begin
            ref_d_r <= ref_s;
            dco_d_r <= dco_s;
        end
    end
    wire ref_rise = ref_s & ~ref_d_r;
    wire dco_rise = dco_s & ~dco_d_r;

    // ****************************************************************
    // apb decode
    // ****************************************************************
    fllcs_sel_t clk_select_reg_r;
    fllcs_octl_t osc_control_reg_r;
    fllcs_flags_t osc_fault_reg_r;
    fllcs_flags_t osc_fault_reg_nxt;
    logic [`FLLCS_FLAG_W-1:0] irq_mask_r;
    logic [`FLLCS_TARGET_W-1:0] target_r;
    logic [W-1:0] word_r;
    logic [W-1:0] word_nxt;
    logic settled_r;

    wire setup = psel & ~penable;
    wire acc_wr = psel & penable & pwrite;
    wire hit_sel = paddr == `FLLCS_OFF_CLKSEL;
    wire hit_ctl = paddr == `FLLCS_OFF_OSCCTL;
    wire hit_flt = paddr == `FLLCS_OFF_FAULT;
    wire hit_msk = paddr == `FLLCS_OFF_MASK;
    wire hit_tgt = paddr == `FLLCS_OFF_TARGET;
    wire hit_wrd = paddr == `FLLCS_OFF_DCOWORD;
    wire hit_any = hit_sel | hit_ctl | hit_flt | hit_msk | hit_tgt | hit_wrd;
    wire wr_sel = acc_wr & hit_sel;
    wire wr_ctl = acc_wr & hit_ctl;
    wire wr_flt = acc_wr & hit_flt;
    wire wr_msk = acc_wr & hit_msk;
    wire wr_tgt = acc_wr & hit_tgt;
    // the word is software owned only while the loop is off
    wire wr_wrd = acc_wr & hit_wrd & ~osc_control_reg_r.fll_en;

    wire [31:0] rd_sel = {21'h0, clk_select_reg_r.aux, 1'b0, clk_select_reg_r.sub, 1'b0,
        clk_select_reg_r.main};
    wire [31:0] rd_ctl = {22'h0, osc_control_reg_r.nmi_en, osc_control_reg_r.fll_en,
        5'h0, osc_control_reg_r.osc2_bypass, osc_control_reg_r.osc1_hf_mode,
        osc_control_reg_r.osc1_bypass_bit};
    wire [31:0] rd_wrd = {15'h0, settled_r, 8'h0, word_r};
    wire [31:0] rd_mux = hit_sel ? rd_sel :
        hit_ctl ? rd_ctl :
        hit_flt ? {29'h0, osc_fault_reg_r} :
        hit_msk ? {29'h0, irq_mask_r} :
        hit_tgt ? {22'h0, target_r} :
        hit_wrd ? rd_wrd : 32'h0000_0000;

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit_any;

    // read data is latched in the setup cycle so it comes from a flop at access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup) begin
            prdata <= rd_mux;
        end
    end

    // ****************************************************************
    // control registers
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_select_reg_r <= `FLLCS_RST_CLKSEL;
            osc_control_reg_r <= `FLLCS_RST_OSCCTL;
            irq_mask_r <= `FLLCS_RST_MASK;
            target_r <= `FLLCS_RST_TARGET;
        end else begin
            if (wr_sel) begin
                clk_select_reg_r.main <= pwdata[`FLLCS_MAIN_LSB +: `FLLCS_SEL_W];
                clk_select_reg_r.sub <= pwdata[`FLLCS_SUB_LSB +: `FLLCS_SEL_W];
                clk_select_reg_r.aux <= pwdata[`FLLCS_AUX_LSB +: `FLLCS_SEL_W];
            end
            if (wr_ctl) begin
                osc_control_reg_r <= {pwdata[9:8], pwdata[2:0]};
            end
            if (wr_msk) begin
                irq_mask_r <= pwdata[`FLLCS_FLAG_W-1:0];
            end
            if (wr_tgt) begin
                target_r <= pwdata[`FLLCS_TARGET_W-1:0];
            end
        end
    end

    // ****************************************************************
    // clock routing and power
    // ****************************************************************
    wire main_pick = src_s[clk_select_reg_r.main];
    wire sub_pick = src_s[clk_select_reg_r.sub];
    wire aux_pick = src_s[clk_select_reg_r.aux];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_clk <= 1'b0;
            sub_clk <= 1'b0;
            aux_clk <= 1'b0;
            low_current_mode <= 1'b0;
        end else begin
            main_clk <= main_pick;
            sub_clk <= sub_pick;
            aux_clk <= aux_pick;
            // bypass state deliberately takes no part in the low current decision
            low_current_mode <= sleep_req;
        end
    end

    assign osc1_bypass = osc_control_reg_r.osc1_bypass_bit;
    assign osc1_hf = osc_control_reg_r.osc1_hf_mode;
    assign osc2_bypass = osc_control_reg_r.osc2_bypass;

    // ****************************************************************
    // frequency locked loop
    // ****************************************************************
    fllcs_state_t state_r;
    fllcs_state_t state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [10:0] settle_cnt_r;

    wire fll_en = osc_control_reg_r.fll_en;
    wire track = state_r == FLLCS_TRACK;
    wire [CNT_W-1:0] tgt = CNT_W'(target_r);
    wire step_up = track & ref_rise & (cnt_r < tgt) & (word_r != {W{1'b1}});
    wire step_dn = track & ref_rise & (cnt_r > tgt) & (word_r != '0);
    wire settle_hit = track & ref_rise & (settle_cnt_r == 11'(`FLLCS_SETTLE_REFS - 1));

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            FLLCS_OFF: if (fll_en) state_nxt = FLLCS_ARM;
            // first reference edge only opens a full counting window
            FLLCS_ARM: if (!fll_en) state_nxt = FLLCS_OFF;
                else if (ref_rise) state_nxt = FLLCS_TRACK;
            FLLCS_TRACK: if (!fll_en) state_nxt = FLLCS_OFF;
            default: state_nxt = FLLCS_OFF;
        endcase
    end

    // one lsb of {tap, fraction} per reference period: fraction carries into tap
    always_comb begin
        word_nxt = word_r;
        if (wr_wrd) begin
            word_nxt = pwdata[W-1:0];
        end else if (step_up) begin
            word_nxt = word_r + 1'b1;
        end else if (step_dn) begin
            word_nxt = word_r - 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= FLLCS_OFF;
            word_r <= `FLLCS_RST_WORD;
            cnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            word_r <= word_nxt;
            if (ref_rise || !fll_en) begin
                cnt_r <= '0;
            end else if (dco_rise && !(&cnt_r)) begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_cnt_r <= '0;
            settled_r <= 1'b0;
        end else if (!fll_en) begin
            settle_cnt_r <= '0;
            settled_r <= 1'b0;
        end else if (track && ref_rise && !settled_r) begin
            settle_cnt_r <= settle_cnt_r + 1'b1;
            settled_r <= settle_hit;
        end
    end

    fllcs_modulator #(
        .TAP_W(TAP_W),
        .MOD_W(MOD_W)
    ) u_mod (
        .pclk(pclk),
        .presetn(presetn),
        .tick(dco_rise),
        .osc_tap_sel(word_r[W-1:MOD_W]),
        .mod_fraction(word_r[MOD_W-1:0]),
        .tap_out(dco_tap)
    );

    // ****************************************************************
    // fault flags and interrupts
    // ****************************************************************
    // only the detector pins set faults; select writes feed nothing here
    wire [`FLLCS_FLAG_W-1:0] flag_set = {settle_hit, f2_s, f1_s};
    wire [`FLLCS_FLAG_W-1:0] flag_clr = wr_flt ? pwdata[`FLLCS_FLAG_W-1:0] : '0;
    assign osc_fault_reg_nxt = (osc_fault_reg_r & ~flag_clr) | flag_set;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_fault_reg_r <= '0;
        end else begin
            osc_fault_reg_r <= osc_fault_reg_nxt;
        end
    end

    wire osc_fault_irq_flag = osc_fault_reg_r.osc1_fault | osc_fault_reg_r.osc2_fault;
    assign osc_fault_nmi = osc_fault_irq_flag & osc_control_reg_r.nmi_en;
    assign irq = |(osc_fault_reg_r & irq_mask_r);

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_top_of_fraction;
        step_up && word_r[MOD_W-1:0] == 5'h1F;
    endsequence

    a_fraction_roll: assert property (s_top_of_fraction |=>
        word_r[MOD_W-1:0] == '0 && word_r[W-1:MOD_W] == $past(word_r[W-1:MOD_W]) + 1'b1)
        else $error("fraction did not roll into tap");

    a_no_tap_jump: assert property (!$past(wr_wrd) &&
        word_r[W-1:MOD_W] > $past(word_r[W-1:MOD_W]) |-> word_r == $past(word_r) + 1'b1)
        else $error("tap rose without a single step");

    a_step_on_ref: assert property (!$past(wr_wrd) && word_r != $past(word_r) |->
        $past(ref_rise) && $past(track))
        else $error("word moved outside a reference edge");

    a_track_up: assert property (step_up |=> word_r == $past(word_r) + 1'b1)
        else $error("loop failed to step up");

    a_settle_time: assert property (settled_r && !$past(settled_r) |->
        $past(settle_cnt_r) == 11'(`FLLCS_SETTLE_REFS - 1))
        else $error("settled at wrong count");

    a_main_route: assert property (##1 main_clk == $past(src_s[clk_select_reg_r.main]))
        else $error("main clock not on selected source");

    a_sel_no_fault: assert property ($rose(osc_fault_reg_r.osc1_fault) |-> $past(f1_s))
        else $error("fault flag set without detector");

    a_fault_nmi: assert property (osc_fault_irq_flag && osc_control_reg_r.nmi_en |->
        osc_fault_nmi ##1
        (osc_fault_nmi || !osc_fault_irq_flag || !osc_control_reg_r.nmi_en))
        else $error("fault nmi missing");

    a_low_current: assert property (sleep_req |=> low_current_mode)
        else $error("deepest sleep did not reach low current");

endmodule
